// >>> asc_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

module asc_dev_end
    import asc_pkg::*;
#(
    parameter logic [3:0]            INIT_SEL      = `ASC_SEL_PAIR1,
    parameter logic [`ASC_NUM_CH-1:0] INIT_MUTE     = '0,
    parameter logic                  INIT_SURROUND = 1'b0,
    parameter logic                  INIT_GAIN_6DB = 1'b0
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    asc_bus_if.device                   bus,
    output var  logic [3:0]             input_select_code,
    output var  logic [1:0]             stereo_pair,
    output var  logic                   six_ch_sel,
    output var  logic                   translate_en,
    output var  logic                   enhance_active,
    output var  logic                   surround_set,
    output var  logic                   mix_gain_6db,
    output var  logic [`ASC_NUM_CH-1:0] mute,
    output var  logic                   cmd_applied
);

    if (!(INIT_SEL inside {`ASC_SEL_PAIR1, `ASC_SEL_PAIR2, `ASC_SEL_PAIR3,
                           `ASC_SEL_PAIR4, `ASC_SEL_SIX})) begin : g_bad_sel
        $error("INIT_SEL is not a legal input selection code");
    end

    asc_dev_state_type state_r;
    logic [3:0]        bit_cnt_r;
    logic [7:0]        shift_r;
    logic [7:0]        cmd_r;
    logic              cmd_ok_r;
    logic              ack_oe_r;
    logic              scl_s1_r;
    logic              scl_s2_r;
    logic              scl_d_r;
    logic              sda_s1_r;
    logic              sda_s2_r;
    logic              sda_d_r;
    logic              start_det;
    logic              stop_det;
    logic              scl_rise;
    logic              scl_fall;
    logic              commit;
    logic              is_insw;
    logic              sel_legal;
    logic              is_mute;
    logic [2:0]        mute_ch;
    logic              mute_val;
    logic [3:0]        sel_r;
    logic              surround_r;
    logic              gain_r;

    // Idle bus level is high, so the synchronisers start there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            scl_s1_r <= bus.scl;
            scl_s2_r <= scl_s1_r;
            scl_d_r  <= scl_s2_r;
            sda_s1_r <= bus.sda;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
        end
    end

    assign scl_rise  = scl_s2_r & ~scl_d_r;
    assign scl_fall  = ~scl_s2_r & scl_d_r;
    assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

    // Framing: a start anywhere, even mid-byte, restarts address reception
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= DS_IDLE;
            bit_cnt_r <= '0;
        end else if (start_det) begin
            state_r   <= DS_ADDR;
            // One short, so the clock fall that closes the start wraps it to bit 0
            bit_cnt_r <= `ASC_CNT_ARM;
        end else if (stop_det) begin
            state_r   <= DS_IDLE;
            bit_cnt_r <= '0;
        end else if (state_r != DS_IDLE && scl_fall) begin
            if (bit_cnt_r == `ASC_ACK_SLOT) begin
                bit_cnt_r <= '0;
                case (state_r)
                    DS_ADDR: state_r <= ack_oe_r ? DS_CMD : DS_DONE;
                    DS_CMD:  state_r <= DS_DONE;
                    default: state_r <= DS_DONE;
                endcase
            end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
    end

    // Bits are taken on the rising clock edge, when they are stable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= '0;
        end else if (scl_rise && bit_cnt_r != `ASC_ACK_SLOT) begin
            shift_r <= {shift_r[6:0], sda_s2_r};
        end
    end

    // Ack is raised after the eighth falling edge and dropped after the ninth
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_oe_r <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_oe_r <= 1'b0;
        end else if (scl_fall) begin
            if (bit_cnt_r == `ASC_LAST_BIT) begin
                ack_oe_r <= (state_r == DS_ADDR && shift_r == `ASC_DEV_ADDR)
                            || state_r == DS_CMD;
            end else begin
                ack_oe_r <= 1'b0;
            end
        end
    end

    // The command is held until the stop so that a cut-off transfer changes nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r    <= '0;
            cmd_ok_r <= 1'b0;
        end else if (start_det || stop_det) begin
            cmd_ok_r <= 1'b0;
        end else if (scl_fall && state_r == DS_CMD && bit_cnt_r == `ASC_ACK_SLOT) begin
            cmd_r    <= shift_r;
            cmd_ok_r <= 1'b1;
        end
    end

    assign commit    = stop_det & cmd_ok_r;
    assign is_insw   = cmd_r[7:4] == `ASC_OP_INSW;
    assign sel_legal = cmd_r[3:0] inside {`ASC_SEL_PAIR1, `ASC_SEL_PAIR2,
                                          `ASC_SEL_PAIR3, `ASC_SEL_PAIR4, `ASC_SEL_SIX};
    assign is_mute   = cmd_r[7:4] == `ASC_OP_MUTE;
    assign mute_ch   = cmd_r[3:1];
    assign mute_val  = cmd_r[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= INIT_SEL;
        end else if (commit && is_insw && sel_legal) begin
            sel_r <= cmd_r[3:0];
        end
    end

    for (genvar ch = 0; ch < `ASC_NUM_CH; ch++) begin : g_mute
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mute[ch] <= INIT_MUTE[ch];
            end else if (commit && is_mute
                         && (mute_ch == 3'(ch) || mute_ch == `ASC_MUTE_ALL)) begin
                mute[ch] <= mute_val;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            surround_r <= INIT_SURROUND;
        end else if (commit && cmd_r == `ASC_CMD_SURR_ON) begin
            surround_r <= 1'b1;
        end else if (commit && cmd_r == `ASC_CMD_SURR_OFF) begin
            surround_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_r <= INIT_GAIN_6DB;
        end else if (commit && cmd_r == `ASC_CMD_GAIN_0DB) begin
            gain_r <= 1'b0;
        end else if (commit && cmd_r == `ASC_CMD_GAIN_6DB) begin
            gain_r <= 1'b1;
        end
    end

    // Routing controls for the analog path, registered one cycle after the settings
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            six_ch_sel     <= 1'b0;
            translate_en   <= 1'b0;
            stereo_pair    <= '0;
            enhance_active <= 1'b0;
            mix_gain_6db   <= 1'b0;
            cmd_applied    <= 1'b0;
        end else begin
            six_ch_sel     <= sel_r == `ASC_SEL_SIX;
            translate_en   <= sel_r != `ASC_SEL_SIX;
            // Pair codes run downward, so the inverted low bits give pair index 0..3
            stereo_pair    <= ~sel_r[1:0];
            enhance_active <= surround_r && sel_r != `ASC_SEL_SIX;
            mix_gain_6db   <= gain_r;
            cmd_applied    <= commit;
        end
    end

    assign input_select_code = sel_r;
    assign surround_set      = surround_r;
    assign bus.dev_sda_o     = 1'b0;
    assign bus.dev_sda_oe    = ack_oe_r;

endmodule : asc_dev_end

`default_nettype wire

// >>> asc_regs.svh
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// Link framing
`define ASC_DEV_ADDR      8'h94
`define ASC_LAST_BIT      4'h7
`define ASC_ACK_SLOT      4'h8
`define ASC_CNT_ARM       4'hf

// Command byte layout
`define ASC_OP_INSW       4'hc
`define ASC_OP_MUTE       4'hf
`define ASC_MUTE_ALL      3'h7
`define ASC_NUM_CH        6
`define ASC_SEL_PAIR4     4'h8
`define ASC_SEL_PAIR3     4'h9
`define ASC_SEL_PAIR2     4'ha
`define ASC_SEL_PAIR1     4'hb
`define ASC_SEL_SIX       4'h7
`define ASC_CMD_SURR_ON   8'hd0
`define ASC_CMD_SURR_OFF  8'hd1
`define ASC_CMD_GAIN_0DB  8'h90
`define ASC_CMD_GAIN_6DB  8'h91

// Timing
`define ASC_CLK_NS        25
`define ASC_BIT_NS        10000
`define ASC_INIT_MS       300
`define ASC_NS_PER_MS     1000000
`define ASC_QTR_CYC       ((`ASC_BIT_NS + 4 * `ASC_CLK_NS - 1) / (4 * `ASC_CLK_NS))
`define ASC_INIT_CYC      (`ASC_INIT_MS * `ASC_NS_PER_MS / `ASC_CLK_NS)

`endif

// >>> asc_pkg.sv
package asc_pkg;

    typedef enum logic [1:0] {DS_IDLE, DS_ADDR, DS_CMD, DS_DONE} asc_dev_state_type;

    typedef enum logic [2:0] {HS_INIT, HS_IDLE, HS_START, HS_BIT, HS_STOP} asc_host_state_type;

    typedef enum logic [1:0] {PH_SETUP, PH_RISE, PH_HIGH, PH_FALL} asc_phase_type;

endpackage : asc_pkg

// >>> asc_bus_if.sv
`timescale 1ns/1ps
`default_nettype none

interface asc_bus_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: any enabled low driver wins
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe);
endinterface : asc_bus_if

`default_nettype wire

// >>> asc_host_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

module asc_host_end
    import asc_pkg::*;
#(
    parameter int INIT_CYC = `ASC_INIT_CYC,
    parameter int QTR_CYC  = `ASC_QTR_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    asc_bus_if.host         bus,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_byte,
    input  wire logic       skip_ack,
    output var  logic       cmd_ready,
    output var  logic       done,
    output var  logic       nack
);

    localparam int QW = $clog2(QTR_CYC + 1);
    localparam int IW = $clog2(INIT_CYC + 1);

    if (QTR_CYC < `ASC_QTR_CYC) begin : g_bad_qtr
        $error("QTR_CYC would clock the bus faster than allowed");
    end
    if (INIT_CYC < 1) begin : g_bad_init
        $error("INIT_CYC must be at least one cycle");
    end

    asc_host_state_type state_r;
    asc_phase_type      phase_r;
    logic [QW-1:0]      qcnt_r;
    logic [IW-1:0]      init_cnt_r;
    logic               tick;
    logic               init_done;
    logic [3:0]         bit_r;
    logic               second_r;
    logic [7:0]         shift_r;
    logic [7:0]         cmd_r;
    logic               skip_r;
    logic               scl_oe_r;
    logic               sda_oe_r;
    logic               sda_s1_r;
    logic               sda_s2_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else begin
            sda_s1_r <= bus.sda;
            sda_s2_r <= sda_s1_r;
        end
    end

    // Power-up hold-off before the first transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt_r <= '0;
        end else if (!init_done) begin
            init_cnt_r <= init_cnt_r + IW'(1);
        end
    end
    assign init_done = init_cnt_r == IW'(INIT_CYC);

    // Quarter-bit timebase, idle outside a transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qcnt_r <= '0;
        end else if (state_r == HS_INIT || state_r == HS_IDLE || tick) begin
            qcnt_r <= '0;
        end else begin
            qcnt_r <= qcnt_r + QW'(1);
        end
    end
    assign tick = qcnt_r == QW'(QTR_CYC - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= HS_INIT;
            phase_r   <= PH_SETUP;
            bit_r     <= '0;
            second_r  <= 1'b0;
            shift_r   <= '0;
            cmd_r     <= '0;
            skip_r    <= 1'b0;
            scl_oe_r  <= 1'b0;
            sda_oe_r  <= 1'b0;
            nack      <= 1'b0;
            done      <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                HS_INIT: if (init_done) begin
                    state_r   <= HS_IDLE;
                    cmd_ready <= 1'b1;
                end
                HS_IDLE: if (cmd_valid) begin
                    shift_r   <= `ASC_DEV_ADDR;
                    cmd_r     <= cmd_byte;
                    skip_r    <= skip_ack;
                    second_r  <= 1'b0;
                    bit_r     <= '0;
                    phase_r   <= PH_SETUP;
                    nack      <= 1'b0;
                    cmd_ready <= 1'b0;
                    state_r   <= HS_START;
                end
                HS_START: if (tick) begin
                    case (phase_r)
                        PH_SETUP: phase_r <= PH_RISE;
                        PH_RISE: begin
                            sda_oe_r <= 1'b1;
                            phase_r  <= PH_HIGH;
                        end
                        default: begin
                            scl_oe_r <= 1'b1;
                            phase_r  <= PH_SETUP;
                            state_r  <= HS_BIT;
                        end
                    endcase
                end
                HS_BIT: if (tick) begin
                    case (phase_r)
                        PH_SETUP: begin
                            // Data moves only with the clock low; ack slot is released
                            sda_oe_r <= bit_r == `ASC_ACK_SLOT ? 1'b0 : ~shift_r[7];
                            phase_r  <= PH_RISE;
                        end
                        PH_RISE: begin
                            scl_oe_r <= 1'b0;
                            phase_r  <= PH_HIGH;
                        end
                        PH_HIGH: begin
                            if (bit_r == `ASC_ACK_SLOT && sda_s2_r && !skip_r) begin
                                nack <= 1'b1;
                            end
                            phase_r <= PH_FALL;
                        end
                        default: begin
                            scl_oe_r <= 1'b1;
                            phase_r  <= PH_SETUP;
                            if (bit_r != `ASC_ACK_SLOT) begin
                                bit_r   <= bit_r + 4'h1;
                                shift_r <= {shift_r[6:0], 1'b0};
                            end else begin
                                bit_r <= '0;
                                if (nack || second_r) begin
                                    state_r <= HS_STOP;
                                end else begin
                                    second_r <= 1'b1;
                                    shift_r  <= cmd_r;
                                end
                            end
                        end
                    endcase
                end
                HS_STOP: if (tick) begin
                    case (phase_r)
                        PH_SETUP: begin
                            sda_oe_r <= 1'b1;
                            phase_r  <= PH_RISE;
                        end
                        PH_RISE: begin
                            scl_oe_r <= 1'b0;
                            phase_r  <= PH_HIGH;
                        end
                        PH_HIGH: begin
                            sda_oe_r <= 1'b0;
                            phase_r  <= PH_FALL;
                        end
                        default: begin
                            done      <= 1'b1;
                            cmd_ready <= 1'b1;
                            phase_r   <= PH_SETUP;
                            state_r   <= HS_IDLE;
                        end
                    endcase
                end
                default: state_r <= HS_IDLE;
            endcase
        end
    end

    assign bus.host_scl_o  = 1'b0;
    assign bus.host_sda_o  = 1'b0;
    assign bus.host_scl_oe = scl_oe_r;
    assign bus.host_sda_oe = sda_oe_r;

endmodule : asc_host_end

`default_nettype wire

// >>> asc_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

module asc_link_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    localparam logic [7:0] ADDR_C    = `ASC_DEV_ADDR;
    localparam int         BIT_CYC_C = `ASC_BIT_NS / `ASC_CLK_NS;

    logic       prev_scl_r;
    logic       prev_sda_r;
    logic [4:0] rise_cnt_r;
    logic       rise_e;
    logic       start_e;
    logic       stop_e;
    logic [9:0] per_cnt_r;

    assign rise_e  = scl && !prev_scl_r;
    assign start_e = scl && prev_scl_r && prev_sda_r && !sda;
    assign stop_e  = scl && prev_scl_r && !prev_sda_r && sda;

    // Idle bus is high, so no false edge right after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_scl_r <= 1'b1;
            prev_sda_r <= 1'b1;
        end else begin
            prev_scl_r <= scl;
            prev_sda_r <= sda;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rise_cnt_r <= 5'h0;
        else if (start_e)
            rise_cnt_r <= 5'h0;
        else if (rise_e)
            rise_cnt_r <= rise_cnt_r + 5'h1;
    end

    // Cycles since the last clock rise; saturates so idle time cannot wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            per_cnt_r <= 10'h3ff;
        else if (rise_e)
            per_cnt_r <= 10'h0;
        else if (per_cnt_r != 10'h3ff)
            per_cnt_r <= per_cnt_r + 10'h1;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        start_e;
    endsequence
    sequence s_stop;
        stop_e;
    endsequence
    sequence s_ack_rise;
        rise_e && (rise_cnt_r == 5'h8 || rise_cnt_r == 5'h11);
    endsequence

    property p_data_stable;
        rise_e |=> $stable(sda) [*8];
    endproperty
    property p_start_clock;
        s_start |=> scl [*8] ##[1:300] !scl;
    endproperty
    property p_stop_count;
        s_stop |-> rise_cnt_r == 5'h13;
    endproperty
    property p_stop_idle;
        s_stop |=> sda [*8];
    endproperty
    property p_addr_msb;
        rise_e && rise_cnt_r < 5'h8 |-> sda == ADDR_C[3'h7 - rise_cnt_r[2:0]];
    endproperty
    property p_ack_low;
        s_ack_rise |-> !sda && dev_sda_oe && !dev_sda_o;
    endproperty
    property p_ack_hold;
        dev_sda_oe && scl |=> dev_sda_oe || !scl;
    endproperty
    property p_host_release;
        s_ack_rise |-> !host_sda_oe ##1 !host_sda_oe [*8];
    endproperty
    property p_scl_rate;
        $fell(scl) && !host_scl_o |=> !scl [*8];
    endproperty
    property p_bit_period;
        rise_e |-> per_cnt_r >= 10'(BIT_CYC_C - 1);
    endproperty

    a_data_stable: assert property (p_data_stable) else $error("data moved while clock high");
    a_start_clock: assert property (p_start_clock) else $error("start not followed by clock");
    a_stop_count: assert property (p_stop_count) else $error("frame clock count wrong");
    a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
    a_addr_msb: assert property (p_addr_msb) else $error("address bit wrong");
    a_ack_low: assert property (p_ack_low) else $error("ack slot not low");
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped while clock high");
    a_host_release: assert property (p_host_release) else $error("host held data in ack");
    a_scl_rate: assert property (p_scl_rate) else $error("clock low phase too short");
    a_bit_period: assert property (p_bit_period) else $error("bit period too short");
endmodule : asc_link_properties

`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

module testbench;
    logic        clk;
    logic        rst_n;
    logic        cmd_valid;
    logic        skip_ack;
    logic [7:0]  cmd_byte;
    logic        cmd_ready;
    logic        done;
    logic        nack;
    logic        bscl;
    logic        bsda;
    logic [3:0]  sel [2];
    logic [1:0]  pair [2];
    logic [5:0]  mute [2];
    logic        six [2];
    logic        trn [2];
    logic        enh [2];
    logic        sur [2];
    logic        gain [2];
    logic        app [2];
    logic [11:0] mdl [2];
    logic [17:0] expq [$];
    logic        nackq [$];
    logic [7:0]  tbl [11];
    int          n_errors;
    int          n_compared;
    int          seed;
    int          k;

    asc_bus_if bus [2] ();

    asc_host_end #(.INIT_CYC(20), .QTR_CYC(100)) asc_host_end_inst (
        .clk(clk), .rst_n(rst_n), .bus(bus[0]), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .skip_ack(skip_ack), .cmd_ready(cmd_ready), .done(done), .nack(nack));

    // Second end is driven bit by bit to reach faults the host never makes
    for (genvar g = 0; g < 2; g++) begin : g_dev
        asc_dev_end asc_dev_end_inst (
            .clk(clk), .rst_n(rst_n), .bus(bus[g]), .input_select_code(sel[g]),
            .stereo_pair(pair[g]), .six_ch_sel(six[g]), .translate_en(trn[g]),
            .enhance_active(enh[g]), .surround_set(sur[g]), .mix_gain_6db(gain[g]),
            .mute(mute[g]), .cmd_applied(app[g]));
    end

    assign bus[1].host_scl_o  = 1'b0;
    assign bus[1].host_sda_o  = 1'b0;
    assign bus[1].host_scl_oe = bscl;
    assign bus[1].host_sda_oe = bsda;

    asc_link_properties asc_link_properties_inst (
        .clk(clk), .rst_n(rst_n), .host_scl_o(bus[0].host_scl_o),
        .host_scl_oe(bus[0].host_scl_oe), .host_sda_o(bus[0].host_sda_o),
        .host_sda_oe(bus[0].host_sda_oe), .dev_sda_o(bus[0].dev_sda_o),
        .dev_sda_oe(bus[0].dev_sda_oe), .scl(bus[0].scl), .sda(bus[0].sda));

    function automatic logic [11:0] nxt(input logic [11:0] st, input logic [7:0] c);
        logic [11:0] r;
        r = st;
        if (c[7:4] == `ASC_OP_INSW && c[3:0] inside {4'h7, 4'h8, 4'h9, 4'ha, 4'hb})
            r[11:8] = c[3:0];
        else if (c[7:4] == `ASC_OP_MUTE && c[3:1] == `ASC_MUTE_ALL)
            r[7:2] = {6{c[0]}};
        else if (c[7:4] == `ASC_OP_MUTE && c[3:1] != 3'h6)
            r[2 + c[3:1]] = c[0];
        else if (c == `ASC_CMD_SURR_ON || c == `ASC_CMD_SURR_OFF)
            r[1] = ~c[0];
        else if (c == `ASC_CMD_GAIN_0DB || c == `ASC_CMD_GAIN_6DB)
            r[0] = c[0];
        return r;
    endfunction : nxt

    function automatic logic [17:0] full(input logic g, input logic [11:0] st);
        logic sx;
        sx = (st[11:8] == `ASC_SEL_SIX);
        return {g, st, ~st[9:8], sx, ~sx, st[1] & ~sx};
    endfunction : full

    function automatic logic [17:0] act(input int g);
        return {g[0], sel[g], mute[g], sur[g], gain[g], pair[g], six[g], trn[g], enh[g]};
    endfunction : act

    task automatic tally_and_finish;
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic bail;
        n_errors++;
        tally_and_finish;
    endtask : bail

    task automatic cmp_state(input logic [17:0] e, input logic [17:0] a);
        n_compared++;
        if (a !== e) begin
            $display("wrong value at %0t: expected %h got %h", $time, e, a);
            n_errors++;
        end
    endtask : cmp_state

    task automatic cmp_bit(input logic e, input logic a);
        n_compared++;
        if (a !== e) begin
            $display("wrong value at %0t: expected %h got %h", $time, e, a);
            n_errors++;
        end
    endtask : cmp_bit

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w

    task automatic bb_bit(input logic b, output logic r);
        w(4);
        bsda = ~b;
        w(1);
        bscl = 1'b0;
        w(2);
        r = bus[1].sda;
        w(1);
        bscl = 1'b1;
    endtask : bb_bit

    // Without a stop the data line is released while the clock is low
    task automatic bb_xfer(input logic [7:0] a, input logic [7:0] c, input logic stop_it,
                           input logic ack_exp);
        logic [15:0] wd;
        logic        r;
        wd = {a, c};
        bsda = 1'b1;
        w(4);
        bscl = 1'b1;
        for (int i = 0; i < 18; i++) begin
            bb_bit((i % 9 == 8) ? 1'b1 : wd[15 - (i - i / 9)], r);
            if (i % 9 == 8)
                cmp_bit(ack_exp, ~r);
        end
        w(4);
        bsda = stop_it;
        w(1);
        bscl = 1'b0;
        w(4);
        bsda = 1'b0;
        w(8);
    endtask : bb_xfer

    task automatic bb_ok(input logic [7:0] c);
        mdl[1] = nxt(mdl[1], c);
        expq.push_back(full(1'b1, mdl[1]));
        bb_xfer(`ASC_DEV_ADDR, c, 1'b1, 1'b1);
    endtask : bb_ok

    task automatic host_cmd(input logic [7:0] c, input logic sk);
        int i;
        for (i = 0; i < 200 && cmd_ready !== 1'b1; i++)
            @(negedge clk);
        if (i == 200)
            bail;
        mdl[0] = nxt(mdl[0], c);
        expq.push_back(full(1'b0, mdl[0]));
        nackq.push_back(1'b0);
        cmd_valid = 1'b1;
        cmd_byte = c;
        skip_ack = sk;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (i = 0; i < 9000 && done !== 1'b1; i++)
            @(negedge clk);
        if (i == 9000)
            bail;
    endtask : host_cmd

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        forever begin
            @(negedge clk);
            if (done === 1'b1)
                cmp_bit(nackq.size() > 0 ? nackq.pop_front() : 1'bx, nack);
        end
    end

    initial begin
        logic gsel;
        forever begin
            @(negedge clk);
            if (app[0] === 1'b1 || app[1] === 1'b1) begin
                gsel = (app[1] === 1'b1);
                @(negedge clk);
                cmp_state(expq.size() > 0 ? expq.pop_front() : 'x, act(gsel));
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        skip_ack = 1'b0;
        bscl = 1'b0;
        bsda = 1'b0;
        n_errors = 0;
        n_compared = 0;
        seed = 16398;
        mdl[0] = {`ASC_SEL_PAIR1, 8'h00};
        mdl[1] = mdl[0];
        tbl = '{8'hc7, 8'hd0, 8'hc8, 8'hc9, 8'hca, 8'hc5, 8'hcb, 8'hd1, 8'h91, 8'h90, 8'haa};
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        w(4);
        cmp_state(full(1'b0, mdl[0]), act(0));
        cmp_state(full(1'b1, mdl[1]), act(1));
        foreach (tbl[i])
            bb_ok(tbl[i]);
        for (int c = 8'hf0; c <= 8'hff; c++)
            bb_ok(c[7:0]);
        k = $random(seed);
        bb_xfer(k[7:0] == `ASC_DEV_ADDR ? 8'h95 : k[7:0], 8'hff, 1'b1, 1'b0);
        bb_xfer(`ASC_DEV_ADDR, 8'hc7, 1'b0, 1'b1);
        bb_ok(8'h91);
        for (int i = 0; i < 4; i++) begin
            k = $random(seed);
            host_cmd(tbl[k[3:0] % 11], k[8]);
        end
        w(20);
        cmp_bit(1'b1, expq.size() == 0 && nackq.size() == 0);
        tally_and_finish;
    end
endmodule : testbench

`default_nettype wire
